// [src/gwd_pkg.sv]
// package: register map, field positions, reset values and timing for the guarded watchdog
package gwd_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_COUNTER = 4'h4;
  localparam logic [3:0] ADDR_CLOCK_SEL = 4'h8;
  // control/status field positions
  localparam int BIT_COUNTER_WE_GUARD = 7;
  localparam int BIT_COUNTER_WRITE_ENABLE = 6;
  localparam int BIT_CONTROL_WE_GUARD = 5;
  localparam int BIT_CONTROL_WRITE_ENABLE = 4;
  localparam int BIT_RUN_GUARD = 3;
  localparam int BIT_WATCHDOG_RUN = 2;
  localparam int BIT_RESET_STATUS_GUARD = 1;
  localparam int BIT_RESET_STATUS = 0;
  localparam int BIT_CLOCK_SEL_TOP = 3;
  // reset values
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [3:0] RST_CLOCK_SEL = 4'hf;
  localparam logic [3:0] CLOCK_SEL_UNUSED = 4'hf;
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  // internal reset length in oscillator cycles
  localparam logic [8:0] CHIP_RESET_OSC_CYCLES = 9'h100;
  // prescaler: taps of clk/64 .. clk/8192 sit at bits 5..12
  localparam int PRESCALE_WIDTH = 13;
  localparam int PRESCALE_FIRST_TAP = 5;
endpackage

// [src/gwd_watchdog.sv]
// guarded watchdog timer: wishbone register slave, prescaler, counter and chip reset
// Contract
// [RULE1] counter write enable changes only when the write carries 0 in bit 7; bit 7 reads 1
// [RULE2] counter writes are taken only while counter write enable is 1
// [RULE3] control write enable changes only when the write carries 0 in bit 5; bit 5 reads 1
// [RULE4] run and reset status bits change by write only while control write enable is 1
// [RULE5] run bit changes only when the write carries 0 in bit 3; bit 3 reads 1
// [RULE6] counter increments while run is 1 and holds while run is 0
// [RULE7] run sets or clears by a guarded enabled write; external reset clears it
// [RULE8] reset status changes only when the write carries 0 in bit 1; bit 1 reads 1
// [RULE9] reset status sets whenever an overflow produces the internal reset
// [RULE10] reset status clears by guarded enabled write of 0 or external reset
// [RULE11] 8-bit up-counter; wrap ff to 00 asserts chip reset and sets status
// [RULE12] counter is zero after reset
// [RULE13] select code 1000..1111 picks clk/64..clk/8192; top bit 0 picks oscillator
// [RULE14] upper four clock select bits always read as 1
// [RULE15] overflow only on the first count pulse after counter holds ff
// [RULE16] internal reset held for 256 oscillator cycles after overflow
// [RULE17] counting resumes from the written value, giving 1 to 256 count periods
// [RULE18] software writes the control/status register as a whole byte
// [RULE19] software starts the watchdog with two writes: enable first, then run
// [RULE20] with oscillator selected the watchdog counts in every chip mode
// [RULE21] one increment per rising edge of the synchronised selected tap
`timescale 1ns/1ps
`default_nettype none
module gwd_watchdog
  import gwd_pkg::*;
(
  // clock and external reset pin
  input wire logic clk_i,
  input wire logic rst_i,
  // internal oscillator, treated as a synchronous level
  input wire logic osc_clk_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // internal chip reset
  output logic chip_reset_o
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic guarded_ok(input logic [7:0] d, input int guard);
    guarded_ok = (d[guard] == 1'b0);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic counter_write_enable, next_counter_write_enable;
  logic control_write_enable, next_control_write_enable;
  logic watchdog_run, next_watchdog_run;
  logic reset_status, next_reset_status;
  logic [7:0] watchdog_counter, next_watchdog_counter;
  logic [3:0] clock_sel, next_clock_sel;
  logic [PRESCALE_WIDTH-1:0] prescale, next_prescale;
  logic tap_q, next_tap_q;
  logic osc_q, next_osc_q;
  logic chip_reset, next_chip_reset;
  logic [8:0] osc_count, next_osc_count;
  logic ack, next_ack;
  logic err, next_err;
  logic [31:0] rdata, next_rdata;

  logic access, wr_low, hit_cs, hit_cnt, hit_sel, mapped;
  logic tap_sel, osc_rise, tap_rise, count_pulse, overflow;
  logic [7:0] wd;
  logic [7:0] cs_read;

  assign access = wb_cyc_i && wb_stb_i && !ack && !err;
  assign wd = wb_dat_i[7:0];
  assign wr_low = access && wb_we_i && wb_sel_i[0];
  assign hit_cs = (wb_adr_i == ADDR_CTRL_STATUS);
  assign hit_cnt = (wb_adr_i == ADDR_COUNTER);
  assign hit_sel = (wb_adr_i == ADDR_CLOCK_SEL);
  assign mapped = hit_cs || hit_cnt || hit_sel;
  // guard bits read back as ones
  assign cs_read = {1'b1, counter_write_enable, 1'b1, control_write_enable,
                    1'b1, watchdog_run, 1'b1, reset_status}; // see [RULE1] see [RULE3] see [RULE5] see [RULE8]

  // ****************************************
  // count clock selection
  // ****************************************
  always_comb begin
    // a switch between taps can look like a rising edge and add one count
    tap_sel = prescale[PRESCALE_FIRST_TAP + 32'(clock_sel[2:0])]; // see [RULE13]
  end
  assign tap_rise = tap_sel && !tap_q; // see [RULE21]
  assign osc_rise = osc_clk_i && !osc_q;
  // oscillator path is never gated by chip mode
  assign count_pulse = clock_sel[BIT_CLOCK_SEL_TOP] ? tap_rise : osc_rise; // see [RULE13] see [RULE20]
  assign overflow = watchdog_run && count_pulse && (watchdog_counter == COUNTER_MAX); // see [RULE15]

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_counter_write_enable = counter_write_enable;
    next_control_write_enable = control_write_enable;
    next_watchdog_run = watchdog_run;
    next_reset_status = reset_status;
    next_watchdog_counter = watchdog_counter;
    next_clock_sel = clock_sel;
    next_prescale = prescale + 1'b1;
    next_tap_q = tap_sel;
    next_osc_q = osc_clk_i;
    next_chip_reset = chip_reset;
    next_osc_count = osc_count;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    if (watchdog_run && count_pulse) begin
      next_watchdog_counter = watchdog_counter + 1'b1; // see [RULE6] see [RULE11]
    end
    if (wr_low && hit_cs) begin
      if (guarded_ok(wd, BIT_COUNTER_WE_GUARD)) begin
        next_counter_write_enable = wd[BIT_COUNTER_WRITE_ENABLE]; // see [RULE1]
      end
      if (guarded_ok(wd, BIT_CONTROL_WE_GUARD)) begin
        next_control_write_enable = wd[BIT_CONTROL_WRITE_ENABLE]; // see [RULE3]
      end
      if (control_write_enable && guarded_ok(wd, BIT_RUN_GUARD)) begin
        next_watchdog_run = wd[BIT_WATCHDOG_RUN]; // see [RULE4] see [RULE5] see [RULE7]
      end
      if (control_write_enable && guarded_ok(wd, BIT_RESET_STATUS_GUARD)) begin
        next_reset_status = wd[BIT_RESET_STATUS]; // see [RULE4] see [RULE8] see [RULE10]
      end
    end
    // software write wins over a same-cycle increment
    if (wr_low && hit_cnt && counter_write_enable) begin
      next_watchdog_counter = wd; // see [RULE2] see [RULE17]
    end
    if (wr_low && hit_sel) begin
      next_clock_sel = wd[3:0];
    end
    // hardware set wins over a software clear
    if (overflow) begin
      next_reset_status = 1'b1; // see [RULE9] see [RULE11]
      next_chip_reset = 1'b1;
      next_osc_count = 9'h000;
    end else if (chip_reset && osc_rise) begin
      if (osc_count == CHIP_RESET_OSC_CYCLES - 9'h001) begin
        next_chip_reset = 1'b0; // see [RULE16]
      end
      next_osc_count = osc_count + 9'h001;
    end
    if (access) begin
      next_ack = mapped;
      next_err = !mapped;
      if (hit_cs) begin
        next_rdata = {24'h000000, cs_read};
      end else if (hit_cnt) begin
        next_rdata = {24'h000000, watchdog_counter};
      end else if (hit_sel) begin
        next_rdata = {24'h000000, CLOCK_SEL_UNUSED, clock_sel}; // see [RULE14]
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_write_enable <= 1'b0;
      control_write_enable <= 1'b0;
      watchdog_run <= 1'b0; // see [RULE7]
      reset_status <= 1'b0; // see [RULE10]
      watchdog_counter <= RST_COUNTER; // see [RULE12]
      clock_sel <= RST_CLOCK_SEL;
      prescale <= '0;
      tap_q <= 1'b0;
      osc_q <= 1'b0;
      chip_reset <= 1'b0;
      osc_count <= 9'h000;
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      counter_write_enable <= next_counter_write_enable;
      control_write_enable <= next_control_write_enable;
      watchdog_run <= next_watchdog_run;
      reset_status <= next_reset_status;
      watchdog_counter <= next_watchdog_counter;
      clock_sel <= next_clock_sel;
      prescale <= next_prescale;
      tap_q <= next_tap_q;
      osc_q <= next_osc_q;
      chip_reset <= next_chip_reset;
      osc_count <= next_osc_count;
      ack <= next_ack;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_err_o = err;
  assign wb_dat_o = rdata;
  assign chip_reset_o = chip_reset;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_cs_write(int g);
    wr_low && hit_cs && wd[g] == 1'b1;
  endsequence

  property p_cwe_guard;
    @(posedge clk_i) disable iff (rst_i)
    s_cs_write(BIT_COUNTER_WE_GUARD) |=> $stable(counter_write_enable);
  endproperty
  a_cwe_guard: assert property (p_cwe_guard) else $error("counter enable changed with guard set"); // see [RULE1]

  property p_counter_locked;
    @(posedge clk_i) disable iff (rst_i)
    wr_low && hit_cnt && !counter_write_enable && !count_pulse |=> $stable(watchdog_counter);
  endproperty
  a_counter_locked: assert property (p_counter_locked) else $error("counter written while locked"); // see [RULE2]

  property p_ctl_guard;
    @(posedge clk_i) disable iff (rst_i)
    s_cs_write(BIT_CONTROL_WE_GUARD) |=> $stable(control_write_enable);
  endproperty
  a_ctl_guard: assert property (p_ctl_guard) else $error("control enable changed with guard set"); // see [RULE3]

  property p_run_locked;
    @(posedge clk_i) disable iff (rst_i)
    !control_write_enable |=> $stable(watchdog_run);
  endproperty
  a_run_locked: assert property (p_run_locked) else $error("run changed while control locked"); // see [RULE4]

  property p_run_set;
    @(posedge clk_i) disable iff (rst_i)
    wr_low && hit_cs && control_write_enable && !wd[BIT_RUN_GUARD]
      |=> watchdog_run == $past(wd[BIT_WATCHDOG_RUN]);
  endproperty
  a_run_set: assert property (p_run_set) else $error("run bit not written"); // see [RULE7]

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    !watchdog_run && !wr_low |=> $stable(watchdog_counter);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while stopped"); // see [RULE6]

  property p_overflow;
    @(posedge clk_i) disable iff (rst_i)
    overflow |=> chip_reset && reset_status
      && (watchdog_counter == 8'h00 || $past(wr_low && hit_cnt && counter_write_enable));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow effects missing"); // see [RULE11]

  property p_reset_read;
    @(posedge clk_i) disable iff (rst_i)
    access && hit_cs |=> rdata[7] && rdata[5] && rdata[3] && rdata[1];
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("guard bits not read as one"); // see [RULE8]

  property p_sel_read;
    @(posedge clk_i) disable iff (rst_i)
    access && hit_sel |=> rdata[7:4] == 4'hf;
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("unused select bits not one"); // see [RULE14]

  property p_reset_len;
    @(posedge clk_i) disable iff (rst_i)
    $rose(chip_reset) |-> osc_count == 9'h000;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset length counter not cleared"); // see [RULE16]

  // ****************************************
  // bus answer, register write, counting and chip reset checks
  // ****************************************
  sequence s_request;
    access;
  endsequence

  sequence s_answer;
    ack || err;
  endsequence

  property p_answer;
    @(posedge clk_i) disable iff (rst_i)
    s_request |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_cwe_set;
    @(posedge clk_i) disable iff (rst_i)
    wr_low && hit_cs && !wd[BIT_COUNTER_WE_GUARD]
      |=> counter_write_enable == $past(wd[BIT_COUNTER_WRITE_ENABLE]);
  endproperty
  a_cwe_set: assert property (p_cwe_set) else $error("counter enable not written"); // see [RULE1]

  property p_ctl_set;
    @(posedge clk_i) disable iff (rst_i)
    wr_low && hit_cs && !wd[BIT_CONTROL_WE_GUARD]
      |=> control_write_enable == $past(wd[BIT_CONTROL_WRITE_ENABLE]);
  endproperty
  a_ctl_set: assert property (p_ctl_set) else $error("control enable not written"); // see [RULE3]

  property p_counter_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_low && hit_cnt && counter_write_enable |=> watchdog_counter == $past(wd);
  endproperty
  a_counter_write: assert property (p_counter_write) else $error("counter write lost"); // see [RULE17]

  property p_status_guard;
    @(posedge clk_i) disable iff (rst_i)
    wr_low && hit_cs && wd[BIT_RESET_STATUS_GUARD] && !overflow |=> $stable(reset_status);
  endproperty
  a_status_guard: assert property (p_status_guard) else $error("status changed with guard set"); // see [RULE8]

  property p_status_locked;
    @(posedge clk_i) disable iff (rst_i)
    !control_write_enable && !overflow |=> $stable(reset_status);
  endproperty
  a_status_locked: assert property (p_status_locked) else $error("status changed while locked"); // see [RULE4]

  property p_status_clear;
    @(posedge clk_i) disable iff (rst_i)
    wr_low && hit_cs && control_write_enable && !wd[BIT_RESET_STATUS_GUARD] && !overflow
      |=> reset_status == $past(wd[BIT_RESET_STATUS]);
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not written"); // see [RULE10]

  property p_status_set;
    @(posedge clk_i) disable iff (rst_i)
    overflow |=> reset_status;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set by overflow"); // see [RULE9]

  property p_count_up;
    @(posedge clk_i) disable iff (rst_i)
    watchdog_run && count_pulse && !wr_low |=> watchdog_counter == $past(watchdog_counter) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step by one"); // see [RULE6]

  property p_no_early;
    @(posedge clk_i) disable iff (rst_i)
    !overflow |=> !$rose(chip_reset);
  endproperty
  a_no_early: assert property (p_no_early) else $error("chip reset without overflow"); // see [RULE15]

  property p_tap_single;
    @(posedge clk_i) disable iff (rst_i)
    tap_rise |=> !tap_rise;
  endproperty
  a_tap_single: assert property (p_tap_single) else $error("two tap edges in a row"); // see [RULE21]

  property p_reset_hold;
    @(posedge clk_i) disable iff (rst_i)
    chip_reset && !osc_rise |=> chip_reset;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("chip reset fell between oscillator edges"); // see [RULE16]

  property p_osc_count;
    @(posedge clk_i) disable iff (rst_i)
    !clock_sel[BIT_CLOCK_SEL_TOP] && watchdog_run && osc_rise && !wr_low |=> $changed(watchdog_counter);
  endproperty
  a_osc_count: assert property (p_osc_count) else $error("oscillator edge not counted"); // see [RULE20]

endmodule // gwd_watchdog
`default_nettype wire

// [verif/guarded_watchdog_timer_bench.sv]
// self-checking bench for the guarded watchdog: register access, counting, overflow and chip reset
`timescale 1ns/1ps
`default_nettype none
module guarded_watchdog_timer_bench;
  import gwd_pkg::*;
  // ***********************************
  // stimulus and design
  // ***********************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic osc_clk_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic chip_reset_o;
  int err_total = 0;
  int checks = 0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0] rnd = 8'h38;
  logic [7:0] q;
  int n;
  int v;
  always #25 clk_i = ~clk_i;
  gwd_watchdog i_gwd_watchdog (.clk_i(clk_i), .rst_i(rst_i), .osc_clk_i(osc_clk_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .chip_reset_o(chip_reset_o));
  // ***********************************
  // reporting
  // ***********************************
  task automatic fail(input string msg);
    err_total++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string msg);
    checks++;
    if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
  endtask
  task automatic chk_bus(input logic [33:0] ex, input logic got_ack, input logic got_err, input logic [31:0] got);
    checks++;
    if (got_err !== ex[32] || got_ack !== !ex[32]) fail("ack or err mismatch");
    else if (ex[33] && got !== ex[31:0]) fail($sformatf("read data got %h want %h", got, ex[31:0]));
  endtask
  // monitor: oldest note against each answer, pre-edge value of the registered answer
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("unexpected answer");
      end else begin
        e = exp_q.pop_front();
        chk_bus(e, wb_ack_o, wb_err_o, wb_dat_o);
      end
    end
  end
  // ***********************************
  // bus and oscillator drivers
  // ***********************************
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [33:0] ex);
    int k = 0;
    exp_q.push_back(ex);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && k < 20);
    q = wb_dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 20) begin
      fail("bus answer missing");
      close_out();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h0, {2'b10, 24'h0, x});
  endtask
  // slow enough that the synchroniser sees every edge
  task automatic osc_pulse();
    @(posedge clk_i); osc_clk_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    osc_clk_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  function automatic logic [7:0] xs(input logic [7:0] s);
    s ^= s << 1; s ^= s >> 1; s ^= s << 2;
    return s;
  endfunction
  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL_STATUS, 8'haa);
    rd(ADDR_COUNTER, 8'h00);
    rd(ADDR_CLOCK_SEL, 8'hff);
    wb(1'b0, 4'hc, 8'h0, {2'b01, 32'h0});
    wr(ADDR_COUNTER, 8'h55);
    rd(ADDR_COUNTER, 8'h00);
    wr(ADDR_CTRL_STATUS, 8'h04);
    rd(ADDR_CTRL_STATUS, 8'haa);
    wr(ADDR_CTRL_STATUS, 8'hd0);
    rd(ADDR_CTRL_STATUS, 8'hba);
    wr(ADDR_CTRL_STATUS, 8'h5c);
    rd(ADDR_CTRL_STATUS, 8'hfa);
    for (int c = 8; c < 16; c++) begin
      wr(ADDR_CLOCK_SEL, 8'(c));
      rd(ADDR_CLOCK_SEL, 8'hf0 | 8'(c));
    end
    // tap clk/64: four periods, phase of the prescaler unknown
    wr(ADDR_CLOCK_SEL, 8'h08);
    wr(ADDR_COUNTER, 8'h00);
    wr(ADDR_CTRL_STATUS, 8'h54);
    repeat (256) @(posedge clk_i);
    wr(ADDR_CTRL_STATUS, 8'h50);
    wb(1'b0, ADDR_COUNTER, 8'h0, 34'h0);
    chk_val({8'h0, q >= 8'd3 && q <= 8'd5}, 9'h1, "prescaled count");
    wr(ADDR_CLOCK_SEL, 8'h00);
    rd(ADDR_CLOCK_SEL, 8'hf0);
    wr(ADDR_COUNTER, 8'h55);
    rd(ADDR_COUNTER, 8'h55);
    repeat (5) osc_pulse();
    rd(ADDR_COUNTER, 8'h55);
    wr(ADDR_CTRL_STATUS, 8'h54);
    rd(ADDR_CTRL_STATUS, 8'hfe);
    repeat (5) osc_pulse();
    rd(ADDR_COUNTER, 8'h5a);
    wr(ADDR_CTRL_STATUS, 8'h50);
    rd(ADDR_CTRL_STATUS, 8'hfa);
    repeat (3) osc_pulse();
    rd(ADDR_COUNTER, 8'h5a);
    for (int i = 0; i < 2; i++) begin
      rnd = xs(rnd);
      v = int'(rnd);
      wr(ADDR_COUNTER, rnd);
      wr(ADDR_CTRL_STATUS, 8'h54);
      n = 0;
      do begin
        osc_pulse();
        n++;
      end while (chip_reset_o !== 1'b1 && n < 300);
      chk_val(9'(n), 9'(256 - v), "pulses to overflow");
      // stop counting so no second wrap lands inside the chip reset
      wr(ADDR_CTRL_STATUS, 8'h52);
      rd(ADDR_CTRL_STATUS, 8'hfb);
      rd(ADDR_COUNTER, 8'h00);
      n = 0;
      do begin
        osc_pulse();
        n++;
      end while (chip_reset_o === 1'b1 && n < 300);
      chk_val(9'(n), CHIP_RESET_OSC_CYCLES, "chip reset length");
      if (i == 0) begin
        wr(ADDR_CTRL_STATUS, 8'h50);
        rd(ADDR_CTRL_STATUS, 8'hfa);
      end else begin
        @(posedge clk_i); rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_CTRL_STATUS, 8'haa);
      end
    end
    repeat (3) @(posedge clk_i);
    chk_val({8'h0, exp_q.size() == 0}, 9'h1, "answers outstanding");
    close_out();
  end
endmodule // guarded_watchdog_timer_bench
`default_nettype wire
